// ===== design/gpp_cfg.svh
`ifndef GPP_CFG_SVH
`define GPP_CFG_SVH

// ****************************************
// register word offsets (byte addresses)
// ****************************************
`define GPP_OFS_OWN 12'h000
`define GPP_OFS_FS0 12'h010
`define GPP_OFS_FS1 12'h020
`define GPP_OFS_FS2 12'h030
`define GPP_OFS_ODE 12'h040
`define GPP_OFS_OLV 12'h050
`define GPP_OFS_PLV 12'h060
`define GPP_OFS_PUE 12'h070
`define GPP_OFS_PDE 12'h080
`define GPP_OFS_IEN 12'h090
`define GPP_OFS_IM0 12'h0A0
`define GPP_OFS_IM1 12'h0B0
`define GPP_OFS_IFL 12'h0D0
`define GPP_OFS_IMSK 12'h0E0

// ****************************************
// alias selector within a 16-byte group
// ****************************************
`define GPP_ALIAS_RW 2'h0
`define GPP_ALIAS_SET 2'h1
`define GPP_ALIAS_CLR 2'h2
`define GPP_ALIAS_TGL 2'h3

// ****************************************
// field codes and reset values
// ****************************************
`define GPP_IMODE_CHANGE 2'h0
`define GPP_IMODE_RISE 2'h1
`define GPP_IMODE_FALL 2'h2
`define GPP_KEEP_NONE 2'h0
`define GPP_KEEP_DOWN 2'h1
`define GPP_KEEP_UP 2'h2
`define GPP_KEEP_BUS 2'h3
`define GPP_RST_WORD 32'h00000000
`define GPP_RST_OWN 32'hFFFFFFFF

`endif

// ===== design/gpp_pkg.sv
package gpp_pkg;
   typedef enum logic [2:0] {
      GPP_BUS_IDLE = 3'b001,
      GPP_BUS_ACK = 3'b010,
      GPP_BUS_DONE = 3'b100
   } gpp_bus_type;

   typedef struct packed {
      gpp_bus_type bus;
      logic [31:0] own;
      logic [31:0] fs0;
      logic [31:0] fs1;
      logic [31:0] fs2;
      logic [31:0] ode;
      logic [31:0] olv;
      logic [31:0] plv;
      logic [31:0] pue;
      logic [31:0] pde;
      logic [31:0] ien;
      logic [31:0] im0;
      logic [31:0] im1;
      logic [31:0] ifl;
      logic [31:0] imsk;
      logic [31:0] rdata;
      logic wait_q;
      logic [31:0] pin_out;
      logic [31:0] pin_oe;
      logic [31:0] pu;
      logic [31:0] pd;
      logic [31:0] bk;
      logic irq;
   } gpp_state_type;
endpackage : gpp_pkg

// ===== design/gpp_port.sv
`timescale 1ns/1ps
`include "gpp_cfg.svh"

// Notes on behaviour
// - ownership bit one gives the pin to GPIO, zero to the chosen peripheral
// - each writable register except the flags sits at base, then set, clear, toggle word aliases
// - three mux planes hold the three-bit function code per pin
// - code with plane2 as msb picks function A (000) to H (111)
// - driver enable bit one turns the pin output driver on while GPIO owns the pin
// - output level bit is the level GPIO drives onto the pin
// - read-only pin level register returns the pin levels last sampled
// - pin level follows the pin only when owned by GPIO or interrupt enabled
// - pin level register after reset holds the pin levels, not a constant
// - pull-up enable bit one enables pull-up unless pull-down enable is also one, zero disables it
// - pull-up and pull-down pair: none, down, up, buskeeper
// - interrupt enable bit one enables detection for that pin
// - two mode planes hold the two-bit interrupt mode per pin
// - mode 00 any change, 01 rising, 10 falling, 11 reserved
// - detected condition sets the pin's interrupt flag while enabled
module gpp_port
   import gpp_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [31:0] pin_in,
   output logic [31:0] pin_out,
   output logic [31:0] pin_oe,
   output logic [31:0] pullup_on,
   output logic [31:0] pulldown_on,
   output logic [31:0] buskeeper_on,
   input wire logic [255:0] periph_out,
   input wire logic [255:0] periph_oe,
   output logic irq
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] alias_apply(input logic [31:0] cur, input logic [1:0] sel,
                                               input logic [31:0] wd);
      case (sel)
         `GPP_ALIAS_RW: alias_apply = wd;
         `GPP_ALIAS_SET: alias_apply = cur | wd;
         `GPP_ALIAS_CLR: alias_apply = cur & ~wd;
         `GPP_ALIAS_TGL: alias_apply = cur ^ wd;
         default: alias_apply = cur;
      endcase
   endfunction : alias_apply

   function automatic logic hits(input logic [11:0] adr, input logic [11:0] base);
      hits = (adr[11:4] == base[11:4]);
   endfunction : hits

   gpp_state_type st_reg;
   gpp_state_type st_next;
   logic [31:0] wmask;
   logic [31:0] wd;
   logic [31:0] sel_out;
   logic [31:0] sel_oe;
   logic [31:0] edge_hit;

   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wd = avs_writedata & wmask;

   // ****************************************
   // per-pin function mux and edge detect
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_pin
         logic [2:0] fsel;
         logic [1:0] imode;
         logic rise;
         logic fall;
         assign fsel = {st_reg.fs2[gi], st_reg.fs1[gi], st_reg.fs0[gi]};
         assign sel_out[gi] = periph_out[{fsel, 5'(gi)}];
         assign sel_oe[gi] = periph_oe[{fsel, 5'(gi)}];
         assign imode = {st_reg.im1[gi], st_reg.im0[gi]};
         assign rise = ~st_reg.plv[gi] & pin_in[gi];
         assign fall = st_reg.plv[gi] & ~pin_in[gi];
         always_comb begin
            case (imode)
               `GPP_IMODE_CHANGE: edge_hit[gi] = rise | fall;
               `GPP_IMODE_RISE: edge_hit[gi] = rise;
               `GPP_IMODE_FALL: edge_hit[gi] = fall;
               default: edge_hit[gi] = 1'b0;
            endcase
         end
      end
   endgenerate

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [31:0] sampled;
      logic [31:0] clr;
      logic [1:0] asel;
      sampled = 32'h00000000;
      clr = 32'h00000000;
      asel = avs_address[3:2];
      st_next = st_reg;
      st_next.wait_q = 1'b1;
      // input path active only for GPIO-owned or interrupt-enabled pins
      sampled = st_reg.own | st_reg.ien;
      st_next.plv = (pin_in & sampled) | (st_reg.plv & ~sampled);
      case (st_reg.bus)
         GPP_BUS_IDLE: begin
            if (avs_write) begin
               if (hits(avs_address, `GPP_OFS_OWN)) st_next.own = alias_apply(st_reg.own, asel, wd);
               if (hits(avs_address, `GPP_OFS_FS0)) st_next.fs0 = alias_apply(st_reg.fs0, asel, wd);
               if (hits(avs_address, `GPP_OFS_FS1)) st_next.fs1 = alias_apply(st_reg.fs1, asel, wd);
               if (hits(avs_address, `GPP_OFS_FS2)) st_next.fs2 = alias_apply(st_reg.fs2, asel, wd);
               if (hits(avs_address, `GPP_OFS_ODE)) st_next.ode = alias_apply(st_reg.ode, asel, wd);
               if (hits(avs_address, `GPP_OFS_OLV)) st_next.olv = alias_apply(st_reg.olv, asel, wd);
               if (hits(avs_address, `GPP_OFS_PUE)) st_next.pue = alias_apply(st_reg.pue, asel, wd);
               if (hits(avs_address, `GPP_OFS_PDE)) st_next.pde = alias_apply(st_reg.pde, asel, wd);
               if (hits(avs_address, `GPP_OFS_IEN)) st_next.ien = alias_apply(st_reg.ien, asel, wd);
               if (hits(avs_address, `GPP_OFS_IM0)) st_next.im0 = alias_apply(st_reg.im0, asel, wd);
               if (hits(avs_address, `GPP_OFS_IM1)) st_next.im1 = alias_apply(st_reg.im1, asel, wd);
               if (hits(avs_address, `GPP_OFS_IMSK)) st_next.imsk = alias_apply(st_reg.imsk, asel, wd);
               // flags clear by writing one at the base or clear alias
               if (hits(avs_address, `GPP_OFS_IFL) && (asel == `GPP_ALIAS_RW || asel == `GPP_ALIAS_CLR))
                  clr = wd;
            end
            if (avs_read) begin
               st_next.rdata = 32'h00000000;
               if (avs_address[3:2] == `GPP_ALIAS_RW) begin
                  case ({4'h0, avs_address[11:4]})
                     `GPP_OFS_OWN >> 4: st_next.rdata = st_reg.own;
                     `GPP_OFS_FS0 >> 4: st_next.rdata = st_reg.fs0;
                     `GPP_OFS_FS1 >> 4: st_next.rdata = st_reg.fs1;
                     `GPP_OFS_FS2 >> 4: st_next.rdata = st_reg.fs2;
                     `GPP_OFS_ODE >> 4: st_next.rdata = st_reg.ode;
                     `GPP_OFS_OLV >> 4: st_next.rdata = st_reg.olv;
                     `GPP_OFS_PLV >> 4: st_next.rdata = st_reg.plv;
                     `GPP_OFS_PUE >> 4: st_next.rdata = st_reg.pue;
                     `GPP_OFS_PDE >> 4: st_next.rdata = st_reg.pde;
                     `GPP_OFS_IEN >> 4: st_next.rdata = st_reg.ien;
                     `GPP_OFS_IM0 >> 4: st_next.rdata = st_reg.im0;
                     `GPP_OFS_IM1 >> 4: st_next.rdata = st_reg.im1;
                     `GPP_OFS_IFL >> 4: st_next.rdata = st_reg.ifl;
                     `GPP_OFS_IMSK >> 4: st_next.rdata = st_reg.imsk;
                     default: st_next.rdata = 32'h00000000;
                  endcase
               end
            end
            if (avs_read || avs_write) begin
               st_next.bus = GPP_BUS_ACK;
               st_next.wait_q = 1'b0;
            end
         end
         GPP_BUS_ACK: st_next.bus = GPP_BUS_DONE;
         GPP_BUS_DONE: st_next.bus = GPP_BUS_IDLE;
         default: st_next.bus = GPP_BUS_IDLE;
      endcase
      // set wins over clear
      st_next.ifl = (st_reg.ifl & ~clr) | (edge_hit & st_reg.ien & sampled);
      st_next.irq = |(st_next.ifl & st_next.imsk);
      // pad drive
      st_next.pin_out = (st_reg.own & st_reg.olv) | (~st_reg.own & sel_out);
      st_next.pin_oe = (st_reg.own & st_reg.ode) | (~st_reg.own & sel_oe);
      st_next.pu = st_reg.pue & ~st_reg.pde;
      st_next.pd = ~st_reg.pue & st_reg.pde;
      st_next.bk = st_reg.pue & st_reg.pde;
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_reg <= st_next;
         st_reg.bus <= GPP_BUS_IDLE;
         st_reg.own <= `GPP_RST_OWN;
         st_reg.fs0 <= `GPP_RST_WORD;
         st_reg.fs1 <= `GPP_RST_WORD;
         st_reg.fs2 <= `GPP_RST_WORD;
         st_reg.ode <= `GPP_RST_WORD;
         st_reg.olv <= `GPP_RST_WORD;
         st_reg.plv <= pin_in;
         st_reg.pue <= `GPP_RST_WORD;
         st_reg.pde <= `GPP_RST_WORD;
         st_reg.ien <= `GPP_RST_WORD;
         st_reg.im0 <= `GPP_RST_WORD;
         st_reg.im1 <= `GPP_RST_WORD;
         st_reg.ifl <= `GPP_RST_WORD;
         st_reg.imsk <= `GPP_RST_WORD;
         st_reg.rdata <= `GPP_RST_WORD;
         st_reg.wait_q <= 1'b1;
         st_reg.pin_out <= `GPP_RST_WORD;
         st_reg.pin_oe <= `GPP_RST_WORD;
         st_reg.pu <= `GPP_RST_WORD;
         st_reg.pd <= `GPP_RST_WORD;
         st_reg.bk <= `GPP_RST_WORD;
         st_reg.irq <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign avs_readdata = st_reg.rdata;
   assign avs_waitrequest = st_reg.wait_q;
   assign pin_out = st_reg.pin_out;
   assign pin_oe = st_reg.pin_oe;
   assign pullup_on = st_reg.pu;
   assign pulldown_on = st_reg.pd;
   assign buskeeper_on = st_reg.bk;
   assign irq = st_reg.irq;

endmodule : gpp_port

// ===== dv/gpp_port_assertions.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module gpp_port_chk (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [31:0] pin_in,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] pullup_on,
   input wire logic [31:0] pulldown_on,
   input wire logic [31:0] buskeeper_on,
   input wire logic [255:0] periph_out,
   input wire logic [255:0] periph_oe,
   input wire logic irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_ack; !avs_waitrequest ##1 avs_waitrequest [*2]; endsequence
   property p_answer; s_req |-> ##[1:3] s_ack; endproperty
   a_answer: assert property (p_answer) else $error("bus access not answered");
   property p_rdata_hold; $changed(avs_readdata) |-> $past(avs_read); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
   property p_keep; ((pullup_on & pulldown_on) | (pullup_on & buskeeper_on) | (pulldown_on & buskeeper_on)) == 0;
   endproperty
   a_keep: assert property (p_keep) else $error("two keepers on one pin");
   property p_oe_cause;
      $changed(pin_oe) |-> $past(avs_write) || $past(avs_write, 2) || $past(periph_oe) != $past(periph_oe, 2);
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("driver enable moved without cause");
   property p_out_cause;
      $changed(pin_out) |-> $past(avs_write) || $past(avs_write, 2) || $past(periph_out) != $past(periph_out, 2);
   endproperty
   a_out_cause: assert property (p_out_cause) else $error("drive level moved without cause");
   property p_rst_quiet; disable iff (1'b0) sys_rst |=> !irq && avs_waitrequest && pin_oe == 32'h00000000;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
   property p_irq_cause;
      $rose(irq) |-> $past(avs_write) || $past(avs_write, 2) || $past(pin_in) != $past(pin_in, 2);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt without pin change");
   property p_busy; $fell(avs_waitrequest) |=> avs_waitrequest [*2]; endproperty
   a_busy: assert property (p_busy) else $error("wait low too long");
endmodule : gpp_port_chk

bind gpp_port gpp_port_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe(pin_oe), .pullup_on(pullup_on), .pulldown_on(pulldown_on), .buskeeper_on(buskeeper_on),
   .periph_out(periph_out), .periph_oe(periph_oe), .irq(irq));

// ===== dv/gpp_pad_model.sv
`timescale 1ns/1ps
// ****
// pads and peripheral functions
// ****
module gpp_pad_model (
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] ext_level,
   output logic [31:0] pin_in,
   output logic [255:0] periph_out,
   output logic [255:0] periph_oe
);
   // a driven pad reads back its own drive, an idle one the outside level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
   for (genvar f = 0; f < 8; f++) begin : g_fn
      assign periph_out[f*32 +: 32] = 32'(32'h11111111 * (f + 1));
      assign periph_oe[f*32 +: 32] = 32'hFFFFFFFF >> (4 * f);
   end
endmodule : gpp_pad_model

// ===== dv/tb.sv
`timescale 1ns/1ps
`include "gpp_cfg.svh"
module tb;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] adr = 12'h000;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] ext_level = 32'h5A5A0F0F;
   logic [31:0] rdat, pin_in, pin_out, pin_oe, pu, pdn, bk, v, e;
   logic [255:0] p_out, p_oe;
   logic wreq, irq;
   logic [11:0] a;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;
   always #20 mclk = ~mclk;
   gpp_port DUT (.mclk(mclk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
      .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pu), .pulldown_on(pdn), .buskeeper_on(bk),
      .periph_out(p_out), .periph_oe(p_oe), .irq(irq));
   gpp_pad_model u_pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in),
      .periph_out(p_out), .periph_oe(p_oe));
   // ****
   // access and compare tasks
   // ****
   task finish_test;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task acc(input logic w, input logic [11:0] ad, input logic [31:0] d);
      adr <= ad;
      wdat <= d;
      rd_en <= !w;
      wr_en <= w;
      @(posedge mclk);
      // wait for the answer; only the cycle ceiling ends a hang
      while (wreq !== 1'b0) begin
         @(posedge mclk);
      end
      v = rdat;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      @(posedge mclk);
   endtask : acc
   task rc(input logic [11:0] ad, input logic [31:0] x);
      acc(1'b0, ad, 32'h00000000);
      chk(v, x);
   endtask : rc
   task rst;
      sys_rst <= 1'b1;
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
   endtask : rst
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         finish_test();
      end
   end
   // ****
   // tests
   // ****
   initial begin
      rst();
      rc(`GPP_OFS_PLV, 32'h5A5A0F0F);
      for (int i = 0; i < 12; i++) begin
         a = 12'(i * 16);
         if (i == 6) continue;
         rc(a, (i == 0) ? 32'hFFFFFFFF : 32'h00000000);
         acc(1'b1, a, 32'hA5A5A5A5);
         acc(1'b1, a + 12'h004, 32'h0000FFFF);
         acc(1'b1, a + 12'h008, 32'hFF000000);
         acc(1'b1, a + 12'h00C, 32'h0F0F0F0F);
         rc(a, 32'h0FAAF0F0);
         rc(a + 12'h004, 32'h00000000);
      end
      acc(1'b1, 12'h1F0, 32'hFFFFFFFF);
      rc(12'h1F0, 32'h00000000);
      rst();
      acc(1'b1, `GPP_OFS_ODE, 32'hFFFF0000);
      acc(1'b1, `GPP_OFS_OLV, 32'h12345678);
      chk(pin_oe, 32'hFFFF0000);
      chk(pin_out & pin_oe, 32'h12340000);
      rc(`GPP_OFS_PLV, 32'h12340F0F);
      acc(1'b1, `GPP_OFS_OWN, 32'h00000000);
      for (int f = 0; f < 8; f++) begin
         acc(1'b1, `GPP_OFS_FS0, {32{f[0]}});
         acc(1'b1, `GPP_OFS_FS1, {32{f[1]}});
         acc(1'b1, `GPP_OFS_FS2, {32{f[2]}});
         e = 32'hFFFFFFFF >> (4 * f);
         chk(pin_oe, e);
         chk(pin_out & pin_oe, 32'(32'h11111111 * (f + 1)) & e);
      end
      acc(1'b1, `GPP_OFS_PUE, 32'h0000000C);
      acc(1'b1, `GPP_OFS_PDE, 32'h0000000A);
      chk(pu, 32'h00000004);
      chk(pdn, 32'h00000002);
      chk(bk, 32'h00000008);
      rc(`GPP_OFS_PLV, 32'h12340F0F);
      acc(1'b1, `GPP_OFS_IEN, 32'hFFFFFFFF);
      ext_level <= 32'h3C3C3C3C;
      // let the pin level register take the new pads before reading it
      @(posedge mclk);
      rc(`GPP_OFS_PLV, 32'h3C3C3C38);
      ext_level <= 32'h00000002;
      rst();
      acc(1'b1, `GPP_OFS_IEN, 32'h0000000F);
      acc(1'b1, `GPP_OFS_IM0, 32'h00000009);
      acc(1'b1, `GPP_OFS_IM1, 32'h0000000A);
      acc(1'b1, `GPP_OFS_IMSK, 32'h0000001F);
      chk({31'h0, irq}, 32'h00000000);
      ext_level <= 32'h0000001D;
      repeat (4) @(posedge mclk);
      chk({31'h0, irq}, 32'h00000001);
      rc(`GPP_OFS_IFL, 32'h00000007);
      acc(1'b1, `GPP_OFS_IMSK, 32'h00000000);
      chk({31'h0, irq}, 32'h00000000);
      acc(1'b1, `GPP_OFS_IFL + 12'h008, 32'h00000007);
      rc(`GPP_OFS_IFL, 32'h00000000);
      ext_level <= 32'h00000000;
      repeat (4) @(posedge mclk);
      rc(`GPP_OFS_IFL, 32'h00000004);
      acc(1'b1, `GPP_OFS_IMSK, 32'h00000004);
      chk({31'h0, irq}, 32'h00000001);
      finish_test();
   end
endmodule : tb
